// [rtl/fsl_prims.sv]
// four-state primitive library: gates, toggle flop and latches
`timescale 1ns/1ps
module fsl_prims #(
	parameter int                        W          = 1,
	parameter int                        N          = 2,
	parameter logic [N-1:0]              AND_IN_INV = '0,
	parameter logic [N-1:0]              OR_IN_INV  = '0,
	parameter logic [fsl_pkg::INV_W-1:0] GATE_INV   = '0,
	parameter logic [fsl_pkg::INV_W-1:0] XOR_INV    = '0,
	parameter logic [fsl_pkg::INV_W-1:0] BUF_INV    = '0,
	parameter logic [fsl_pkg::INV_W-1:0] TSD_INV    = '0,
	parameter logic [fsl_pkg::INV_W-1:0] ID_INV     = '0,
	parameter logic [fsl_pkg::INV_W-1:0] TF_INV     = '0,
	parameter logic [fsl_pkg::INV_W-1:0] LT_INV     = '0,
	parameter logic [fsl_pkg::INV_W-1:0] FL_INV     = '0,
	parameter logic [fsl_pkg::INV_W-1:0] DL_INV     = '0
) (
	input  wire logic                     SYS_CLK,
	input  wire logic                     SYS_RST,
	input  wire logic [N-1:0][W-1:0][1:0] AND_IN,
	output logic      [W-1:0][1:0]        AND_OUT,
	input  wire logic [N-1:0][W-1:0][1:0] OR_IN,
	output logic      [W-1:0][1:0]        OR_OUT,
	input  wire logic [W-1:0][1:0]        XOR_A,
	input  wire logic [W-1:0][1:0]        XOR_B,
	output logic      [W-1:0][1:0]        XOR_OUT,
	input  wire logic [W-1:0][1:0]        BUF_IN,
	output logic      [W-1:0][1:0]        BUF_OUT,
	input  wire logic [W-1:0][1:0]        TSD_IN,
	input  wire logic [1:0]               TSD_EN_N,
	output logic      [W-1:0][1:0]        TSD_OUT,
	input  wire logic [W-1:0][1:0]        ID_IN,
	input  wire logic [W-1:0]             ID_WEAK_IN,
	output logic      [W-1:0][1:0]        ID_OUT,
	output logic      [W-1:0]             ID_WEAK_OUT,
	input  wire logic [W-1:0][1:0]        TF_J,
	input  wire logic [W-1:0][1:0]        TF_K,
	input  wire logic [1:0]               TF_CLK,
	input  wire logic [1:0]               TF_FORCE_ONE_N,
	input  wire logic [1:0]               TF_FORCE_ZERO_N,
	output logic      [W-1:0][1:0]        TF_Q,
	output logic      [W-1:0][1:0]        TF_Q_N,
	input  wire logic [W-1:0][1:0]        LT_D,
	input  wire logic [1:0]               LT_EN,
	output logic      [W-1:0][1:0]        LT_Q,
	input  wire logic [W-1:0][1:0]        FL_D,
	input  wire logic [1:0]               FL_EN,
	input  wire logic [1:0]               FL_FORCE_ONE_N,
	input  wire logic [1:0]               FL_FORCE_ZERO_N,
	output logic      [W-1:0][1:0]        FL_Q,
	input  wire logic [W-1:0][1:0]        DL_D,
	input  wire logic [1:0]               DL_EN,
	input  wire logic [1:0]               DL_FORCE_ONE_N,
	input  wire logic [1:0]               DL_FORCE_ZERO_N,
	output logic      [W-1:0][1:0]        DL_Q,
	output logic      [W-1:0][1:0]        DL_Q_N
);
	localparam logic [2*W-1:0] ALL_U = {W{fsl_pkg::FS_U}};

	// ----------------------------------------------------------------
	// combinational gate unit
	// ----------------------------------------------------------------
	fsl_gate_if #(.W(W), .N(N)) gate ();

	assign gate.and_in   = AND_IN;
	assign gate.or_in    = OR_IN;
	assign gate.xor_a    = XOR_A;
	assign gate.xor_b    = XOR_B;
	assign gate.buf_in   = BUF_IN;
	assign gate.tsd_in   = TSD_IN;
	assign gate.tsd_en_n = TSD_EN_N;
	assign gate.id_in    = ID_IN;

	fsl_gate_unit #(
		.W          (W),
		.N          (N),
		.AND_IN_INV (AND_IN_INV),
		.OR_IN_INV  (OR_IN_INV),
		.GATE_INV   (GATE_INV),
		.XOR_INV    (XOR_INV),
		.BUF_INV    (BUF_INV),
		.TSD_INV    (TSD_INV),
		.ID_INV     (ID_INV)
	) u_gate (
		.u (gate.unit)
	);

	// --------------------------------
	// registered gate outputs
	// --------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			AND_OUT     <= ALL_U;
			OR_OUT      <= ALL_U;
			XOR_OUT     <= ALL_U;
			BUF_OUT     <= ALL_U;
			TSD_OUT     <= ALL_U;
			ID_OUT      <= ALL_U;
			ID_WEAK_OUT <= '0;
		end else begin
			AND_OUT     <= gate.and_out;
			OR_OUT      <= gate.or_out;
			XOR_OUT     <= gate.xor_out;
			BUF_OUT     <= gate.buf_out;
			TSD_OUT     <= gate.tsd_out;
			ID_OUT      <= gate.id_out;
			ID_WEAK_OUT <= ID_WEAK_IN;
		end
	end

	// ----------------------------------------------------------------
	// toggle flop: one-bit controls after pin polarity
	// ----------------------------------------------------------------
	fsl_pkg::fsl_bit_t   tf_clk;
	fsl_pkg::fsl_bit_t   tf_clk_prev;
	fsl_pkg::fsl_bit_t   tf_one_n;
	fsl_pkg::fsl_bit_t   tf_zero_n;
	fsl_pkg::fsl_force_t tf_force;
	logic                tf_clk_moved;
	logic                tf_rise;
	logic                tf_to_unk;

	assign tf_clk       = fsl_pkg::fs_pol(TF_CLK, TF_INV[fsl_pkg::INV_CTL]);
	assign tf_one_n     = fsl_pkg::fs_pol(TF_FORCE_ONE_N, TF_INV[fsl_pkg::INV_ONE]);
	assign tf_zero_n    = fsl_pkg::fs_pol(TF_FORCE_ZERO_N, TF_INV[fsl_pkg::INV_ZERO]);
	assign tf_force     = fsl_pkg::fs_force(tf_one_n, tf_zero_n);
	assign tf_clk_moved = (tf_clk != tf_clk_prev);
	assign tf_rise      = (tf_clk_prev == fsl_pkg::FS_0) && (tf_clk == fsl_pkg::FS_1);
	// a move onto z or u clouds the flop when no force is active
	assign tf_to_unk    = !fsl_pkg::fs_known(tf_clk) && tf_clk_moved;

	// --------------------------------
	// clock history for edge detection
	// --------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			tf_clk_prev <= fsl_pkg::FS_U;
		else
			tf_clk_prev <= tf_clk;
	end

	// ----------------------------------------------------------------
	// latch controls after pin polarity
	// ----------------------------------------------------------------
	fsl_pkg::fsl_bit_t   lt_en;
	fsl_pkg::fsl_bit_t   fl_en;
	fsl_pkg::fsl_bit_t   fl_one_n;
	fsl_pkg::fsl_bit_t   fl_zero_n;
	fsl_pkg::fsl_bit_t   dl_en;
	fsl_pkg::fsl_force_t dl_force;
	logic                fl_zero_on;
	logic                fl_zero_unk;
	logic                fl_one_on;
	logic                fl_one_unk;

	assign lt_en     = fsl_pkg::fs_pol(LT_EN, LT_INV[fsl_pkg::INV_CTL]);
	assign fl_en     = fsl_pkg::fs_pol(FL_EN, FL_INV[fsl_pkg::INV_CTL]);
	assign fl_one_n  = fsl_pkg::fs_pol(FL_FORCE_ONE_N, FL_INV[fsl_pkg::INV_ONE]);
	assign fl_zero_n = fsl_pkg::fs_pol(FL_FORCE_ZERO_N, FL_INV[fsl_pkg::INV_ZERO]);
	assign dl_en     = fsl_pkg::fs_pol(DL_EN, DL_INV[fsl_pkg::INV_CTL]);
	assign dl_force  = fsl_pkg::fs_force(
		fsl_pkg::fs_pol(DL_FORCE_ONE_N, DL_INV[fsl_pkg::INV_ONE]),
		fsl_pkg::fs_pol(DL_FORCE_ZERO_N, DL_INV[fsl_pkg::INV_ZERO]));

	assign fl_zero_on  = (fl_zero_n == fsl_pkg::FS_0);
	assign fl_zero_unk = !fsl_pkg::fs_known(fl_zero_n);
	assign fl_one_on   = (fl_one_n == fsl_pkg::FS_0);
	assign fl_one_unk  = !fsl_pkg::fs_known(fl_one_n);

	// ----------------------------------------------------------------
	// per-bit state of the sequential primitives
	// ----------------------------------------------------------------
	for (genvar b = 0; b < W; b++) begin : g_seq
		fsl_pkg::fsl_bit_t tf_j;
		fsl_pkg::fsl_bit_t tf_k;
		fsl_pkg::fsl_bit_t tf_q;
		fsl_pkg::fsl_bit_t tf_qn;
		fsl_pkg::fsl_bit_t next_tf_q;
		fsl_pkg::fsl_bit_t next_tf_qn;
		fsl_pkg::fsl_bit_t tf_edge_q;
		fsl_pkg::fsl_bit_t tf_edge_qn;
		fsl_pkg::fsl_bit_t lt_q;
		fsl_pkg::fsl_bit_t next_lt_q;
		fsl_pkg::fsl_bit_t fl_q;
		fsl_pkg::fsl_bit_t fl_latch;
		fsl_pkg::fsl_bit_t next_fl_q;
		fsl_pkg::fsl_bit_t dl_d;
		fsl_pkg::fsl_bit_t dl_q;
		fsl_pkg::fsl_bit_t dl_qn;
		fsl_pkg::fsl_bit_t next_dl_q;
		fsl_pkg::fsl_bit_t next_dl_qn;
		fsl_pkg::fsl_bit_t dl_d_n;
		fsl_pkg::fsl_bit_t dl_lat_q;
		fsl_pkg::fsl_bit_t dl_lat_qn;
		fsl_pkg::fsl_bit_t tf_q_pin;
		fsl_pkg::fsl_bit_t tf_qn_pin;
		fsl_pkg::fsl_bit_t lt_q_pin;
		fsl_pkg::fsl_bit_t fl_q_pin;
		fsl_pkg::fsl_bit_t dl_q_pin;
		fsl_pkg::fsl_bit_t dl_qn_pin;

		// --------------------------------
		// toggle flop data after pin polarity
		// --------------------------------
		assign tf_j = fsl_pkg::fs_pol(TF_J[b], TF_INV[fsl_pkg::INV_D]);
		assign tf_k = fsl_pkg::fs_pol(TF_K[b], TF_INV[fsl_pkg::INV_K]);

		// j and k swap roles on the inverted rail
		assign tf_edge_q  = fsl_pkg::fs_tf_next(tf_j, tf_k, tf_q);
		assign tf_edge_qn = fsl_pkg::fs_tf_next(tf_k, tf_j, tf_qn);

		// --------------------------------
		// toggle flop next state, forces before the clock event
		// --------------------------------
		always_comb begin
			case (tf_force)
				fsl_pkg::FRC_UNK: begin
					next_tf_q  = fsl_pkg::FS_U;
					next_tf_qn = fsl_pkg::FS_U;
				end
				fsl_pkg::FRC_BOTH: begin
					next_tf_q  = fsl_pkg::FS_1;
					next_tf_qn = fsl_pkg::FS_1;
				end
				fsl_pkg::FRC_ONE: begin
					next_tf_q  = fsl_pkg::FS_1;
					next_tf_qn = fsl_pkg::FS_0;
				end
				fsl_pkg::FRC_ZERO: begin
					next_tf_q  = fsl_pkg::FS_0;
					next_tf_qn = fsl_pkg::FS_1;
				end
				default: begin
					if (tf_to_unk) begin
						next_tf_q  = fsl_pkg::FS_U;
						next_tf_qn = fsl_pkg::FS_U;
					end else if (tf_rise) begin
						next_tf_q  = tf_edge_q;
						next_tf_qn = tf_edge_qn;
					end else begin
						next_tf_q  = tf_q;
						next_tf_qn = tf_qn;
					end
				end
			endcase
		end

		// --------------------------------
		// plain latch
		// --------------------------------
		assign next_lt_q = fsl_pkg::fs_latch(
			fsl_pkg::fs_pol(LT_D[b], LT_INV[fsl_pkg::INV_D]), lt_en, lt_q);

		// --------------------------------
		// single-output forced latch: clearing force checked first
		// --------------------------------
		assign fl_latch  = fsl_pkg::fs_latch(
			fsl_pkg::fs_pol(FL_D[b], FL_INV[fsl_pkg::INV_D]), fl_en, fl_q);
		assign next_fl_q = fl_zero_on ? fsl_pkg::FS_0 :
			fl_zero_unk ? fsl_pkg::FS_U :
			fl_one_on ? fsl_pkg::FS_1 :
			fl_one_unk ? fsl_pkg::FS_U : fl_latch;

		// --------------------------------
		// dual rail forced latch
		// --------------------------------
		assign dl_d      = fsl_pkg::fs_pol(DL_D[b], DL_INV[fsl_pkg::INV_D]);
		assign dl_d_n    = fsl_pkg::fs_pol(dl_d, 1'h1);
		assign dl_lat_q  = fsl_pkg::fs_latch(dl_d, dl_en, dl_q);
		assign dl_lat_qn = fsl_pkg::fs_latch(dl_d_n, dl_en, dl_qn);

		always_comb begin
			case (dl_force)
				fsl_pkg::FRC_UNK: begin
					next_dl_q  = fsl_pkg::FS_U;
					next_dl_qn = fsl_pkg::FS_U;
				end
				fsl_pkg::FRC_BOTH: begin
					next_dl_q  = fsl_pkg::FS_1;
					next_dl_qn = fsl_pkg::FS_1;
				end
				fsl_pkg::FRC_ONE: begin
					next_dl_q  = fsl_pkg::FS_1;
					next_dl_qn = fsl_pkg::FS_0;
				end
				fsl_pkg::FRC_ZERO: begin
					next_dl_q  = fsl_pkg::FS_0;
					next_dl_qn = fsl_pkg::FS_1;
				end
				default: begin
					next_dl_q  = dl_lat_q;
					next_dl_qn = dl_lat_qn;
				end
			endcase
		end

		// ------------------------------------------------------------
		// internal state, unknown after reset
		// ------------------------------------------------------------
		always_ff @(posedge SYS_CLK) begin
			if (SYS_RST) begin
				tf_q  <= fsl_pkg::FS_U;
				tf_qn <= fsl_pkg::FS_U;
				lt_q  <= fsl_pkg::FS_U;
				fl_q  <= fsl_pkg::FS_U;
				dl_q  <= fsl_pkg::FS_U;
				dl_qn <= fsl_pkg::FS_U;
			end else begin
				tf_q  <= next_tf_q;
				tf_qn <= next_tf_qn;
				lt_q  <= next_lt_q;
				fl_q  <= next_fl_q;
				dl_q  <= next_dl_q;
				dl_qn <= next_dl_qn;
			end
		end

		// ------------------------------------------------------------
		// pin polarity ahead of the output register
		// ------------------------------------------------------------
		assign tf_q_pin  = fsl_pkg::fs_pol(next_tf_q, TF_INV[fsl_pkg::INV_Q]);
		assign tf_qn_pin = fsl_pkg::fs_pol(next_tf_qn, TF_INV[fsl_pkg::INV_QN]);
		assign lt_q_pin  = fsl_pkg::fs_pol(next_lt_q, LT_INV[fsl_pkg::INV_Q]);
		assign fl_q_pin  = fsl_pkg::fs_pol(next_fl_q, FL_INV[fsl_pkg::INV_Q]);
		assign dl_q_pin  = fsl_pkg::fs_pol(next_dl_q, DL_INV[fsl_pkg::INV_Q]);
		assign dl_qn_pin = fsl_pkg::fs_pol(next_dl_qn, DL_INV[fsl_pkg::INV_QN]);

		// ------------------------------------------------------------
		// output pin registers
		// ------------------------------------------------------------
		always_ff @(posedge SYS_CLK) begin
			if (SYS_RST) begin
				TF_Q[b]   <= fsl_pkg::FS_U;
				TF_Q_N[b] <= fsl_pkg::FS_U;
				LT_Q[b]   <= fsl_pkg::FS_U;
				FL_Q[b]   <= fsl_pkg::FS_U;
				DL_Q[b]   <= fsl_pkg::FS_U;
				DL_Q_N[b] <= fsl_pkg::FS_U;
			end else begin
				TF_Q[b]   <= tf_q_pin;
				TF_Q_N[b] <= tf_qn_pin;
				LT_Q[b]   <= lt_q_pin;
				FL_Q[b]   <= fl_q_pin;
				DL_Q[b]   <= dl_q_pin;
				DL_Q_N[b] <= dl_qn_pin;
			end
		end
	end
endmodule

// [include/fsl_pkg.sv]
// four-state encoding, pin polarity indices and evaluation functions
package fsl_pkg;

	// ----------------------------------------------------------------
	// value encoding
	// ----------------------------------------------------------------
	typedef logic [1:0] fsl_bit_t;
	localparam fsl_bit_t FS_0 = 2'h0;
	localparam fsl_bit_t FS_1 = 2'h1;
	localparam fsl_bit_t FS_Z = 2'h2;
	localparam fsl_bit_t FS_U = 2'h3;

	localparam int FS_MIN_INPUTS = 2;
	localparam int FS_MAX_INPUTS = 8;

	// ----------------------------------------------------------------
	// positions in a pin inversion mask
	// ----------------------------------------------------------------
	localparam int INV_W    = 7;
	localparam int INV_D    = 0;
	localparam int INV_CTL  = 1;
	localparam int INV_ONE  = 2;
	localparam int INV_ZERO = 3;
	localparam int INV_Q    = 4;
	localparam int INV_QN   = 5;
	localparam int INV_K    = 6;

	typedef enum logic [2:0] {
		FRC_NONE = 3'h0,
		FRC_ONE  = 3'h1,
		FRC_BOTH = 3'h3,
		FRC_ZERO = 3'h2,
		FRC_UNK  = 3'h6
	} fsl_force_t;

	// ----------------------------------------------------------------
	// evaluation functions
	// ----------------------------------------------------------------
	function automatic logic fs_known(input fsl_bit_t v);
		fs_known = (v == FS_0) || (v == FS_1);
	endfunction

	function automatic fsl_bit_t fs_pol(input fsl_bit_t v, input logic inv);
		if (inv && v == FS_0)
			fs_pol = FS_1;
		else if (inv && v == FS_1)
			fs_pol = FS_0;
		else
			fs_pol = v;
	endfunction

	function automatic fsl_bit_t fs_buf(input fsl_bit_t v);
		fs_buf = fs_known(v) ? v : FS_U;
	endfunction

	function automatic fsl_bit_t fs_and2(input fsl_bit_t a, input fsl_bit_t b);
		if (a == FS_0 || b == FS_0)
			fs_and2 = FS_0;
		else
			fs_and2 = (a == FS_1 && b == FS_1) ? FS_1 : FS_U;
	endfunction

	function automatic fsl_bit_t fs_or2(input fsl_bit_t a, input fsl_bit_t b);
		if (a == FS_1 || b == FS_1)
			fs_or2 = FS_1;
		else
			fs_or2 = (a == FS_0 && b == FS_0) ? FS_0 : FS_U;
	endfunction

	function automatic fsl_bit_t fs_xor2(input fsl_bit_t a, input fsl_bit_t b);
		if (fs_known(a) && fs_known(b))
			fs_xor2 = (a == b) ? FS_0 : FS_1;
		else
			fs_xor2 = FS_U;
	endfunction

	function automatic fsl_force_t fs_force(input fsl_bit_t one_n, input fsl_bit_t zero_n);
		if (!fs_known(one_n) || !fs_known(zero_n))
			fs_force = FRC_UNK;
		else if (one_n == FS_0 && zero_n == FS_0)
			fs_force = FRC_BOTH;
		else if (one_n == FS_0)
			fs_force = FRC_ONE;
		else if (zero_n == FS_0)
			fs_force = FRC_ZERO;
		else
			fs_force = FRC_NONE;
	endfunction

	function automatic fsl_bit_t fs_latch(input fsl_bit_t d, input fsl_bit_t en,
		input fsl_bit_t previous_state);
		if (en == FS_0)
			fs_latch = previous_state;
		else if (en == FS_1)
			fs_latch = fs_buf(d);
		else
			fs_latch = (d == previous_state) ? previous_state : FS_U;
	endfunction

	// true rail; the inverted rail is the same call with j and k swapped
	function automatic fsl_bit_t fs_tf_next(input fsl_bit_t j, input fsl_bit_t k,
		input fsl_bit_t q);
		if (!fs_known(j) || !fs_known(k))
			fs_tf_next = FS_U;
		else if (j == FS_0 && k == FS_0)
			fs_tf_next = q;
		else if (j == FS_0)
			fs_tf_next = FS_0;
		else if (k == FS_0)
			fs_tf_next = FS_1;
		else
			fs_tf_next = fs_pol(q, 1'h1);
	endfunction

endpackage

// [include/fsl_gate_if.sv]
// signals between the library top and its combinational gate unit
`timescale 1ns/1ps
interface fsl_gate_if #(
	parameter int W = 1,
	parameter int N = 2
);
	logic [N-1:0][W-1:0][1:0] and_in;
	logic [N-1:0][W-1:0][1:0] or_in;
	logic [W-1:0][1:0]        xor_a;
	logic [W-1:0][1:0]        xor_b;
	logic [W-1:0][1:0]        buf_in;
	logic [W-1:0][1:0]        tsd_in;
	logic [1:0]               tsd_en_n;
	logic [W-1:0][1:0]        id_in;
	logic [W-1:0][1:0]        and_out;
	logic [W-1:0][1:0]        or_out;
	logic [W-1:0][1:0]        xor_out;
	logic [W-1:0][1:0]        buf_out;
	logic [W-1:0][1:0]        tsd_out;
	logic [W-1:0][1:0]        id_out;

	modport unit (
		input  and_in, or_in, xor_a, xor_b, buf_in, tsd_in, tsd_en_n, id_in,
		output and_out, or_out, xor_out, buf_out, tsd_out, id_out
	);
	modport user (
		output and_in, or_in, xor_a, xor_b, buf_in, tsd_in, tsd_en_n, id_in,
		input  and_out, or_out, xor_out, buf_out, tsd_out, id_out
	);
endinterface

// [rtl/fsl_gate_unit.sv]
// combinational four-state gates, buffers and identity path
`timescale 1ns/1ps
module fsl_gate_unit #(
	parameter int                            W           = 1,
	parameter int                            N           = 2,
	parameter logic [N-1:0]                  AND_IN_INV  = '0,
	parameter logic [N-1:0]                  OR_IN_INV   = '0,
	parameter logic [fsl_pkg::INV_W-1:0]     GATE_INV    = '0,
	parameter logic [fsl_pkg::INV_W-1:0]     XOR_INV     = '0,
	parameter logic [fsl_pkg::INV_W-1:0]     BUF_INV     = '0,
	parameter logic [fsl_pkg::INV_W-1:0]     TSD_INV     = '0,
	parameter logic [fsl_pkg::INV_W-1:0]     ID_INV      = '0
) (
	fsl_gate_if.unit u
);
	fsl_pkg::fsl_bit_t tsd_en;

	assign tsd_en = fsl_pkg::fs_pol(u.tsd_en_n, TSD_INV[fsl_pkg::INV_CTL]);

	for (genvar b = 0; b < W; b++) begin : g_bit
		fsl_pkg::fsl_bit_t and_acc;
		fsl_pkg::fsl_bit_t or_acc;
		fsl_pkg::fsl_bit_t tsd_raw;

		// ----------------------------------------------------------------
		// wide gates folded over the inputs
		// ----------------------------------------------------------------
		always_comb begin
			and_acc = fsl_pkg::FS_1;
			or_acc  = fsl_pkg::FS_0;
			for (int i = 0; i < N; i++) begin
				and_acc = fsl_pkg::fs_and2(and_acc,
					fsl_pkg::fs_pol(u.and_in[i][b], AND_IN_INV[i]));
				or_acc  = fsl_pkg::fs_or2(or_acc,
					fsl_pkg::fs_pol(u.or_in[i][b], OR_IN_INV[i]));
			end
		end

		assign u.and_out[b] = fsl_pkg::fs_pol(and_acc, GATE_INV[fsl_pkg::INV_Q]);
		assign u.or_out[b]  = fsl_pkg::fs_pol(or_acc, GATE_INV[fsl_pkg::INV_QN]);
		assign u.xor_out[b] = fsl_pkg::fs_pol(fsl_pkg::fs_xor2(
			fsl_pkg::fs_pol(u.xor_a[b], XOR_INV[fsl_pkg::INV_D]),
			fsl_pkg::fs_pol(u.xor_b[b], XOR_INV[fsl_pkg::INV_K])),
			XOR_INV[fsl_pkg::INV_Q]);
		assign u.buf_out[b] = fsl_pkg::fs_pol(fsl_pkg::fs_buf(
			fsl_pkg::fs_pol(u.buf_in[b], BUF_INV[fsl_pkg::INV_D])),
			BUF_INV[fsl_pkg::INV_Q]);

		// ----------------------------------------------------------------
		// three-state driver and identity
		// ----------------------------------------------------------------
		assign tsd_raw = (tsd_en == fsl_pkg::FS_0) ? fsl_pkg::fs_buf(
			fsl_pkg::fs_pol(u.tsd_in[b], TSD_INV[fsl_pkg::INV_D])) :
			(tsd_en == fsl_pkg::FS_1) ? fsl_pkg::FS_Z : fsl_pkg::FS_U;
		assign u.tsd_out[b] = fsl_pkg::fs_pol(tsd_raw, TSD_INV[fsl_pkg::INV_Q]);
		assign u.id_out[b]  = fsl_pkg::fs_pol(fsl_pkg::fs_pol(u.id_in[b],
			ID_INV[fsl_pkg::INV_D]), ID_INV[fsl_pkg::INV_Q]);
	end
endmodule

// [dv/fsl_prims_properties.sv]
// concurrent checks on the ports of the four-state primitive library
`timescale 1ns/1ps
module fsl_prims_properties #(
	parameter int                        W        = 1,
	parameter int                        N        = 2,
	parameter logic [fsl_pkg::INV_W-1:0] GATE_INV = '0
) (
	input wire logic                     SYS_CLK,
	input wire logic                     SYS_RST,
	input wire logic [N-1:0][W-1:0][1:0] AND_IN,
	input wire logic [W-1:0][1:0]        AND_OUT,
	input wire logic [N-1:0][W-1:0][1:0] OR_IN,
	input wire logic [W-1:0][1:0]        OR_OUT,
	input wire logic [W-1:0][1:0]        BUF_IN,
	input wire logic [W-1:0][1:0]        BUF_OUT,
	input wire logic [1:0]               TSD_EN_N,
	input wire logic [W-1:0][1:0]        TSD_OUT,
	input wire logic [W-1:0][1:0]        ID_IN,
	input wire logic [W-1:0]             ID_WEAK_IN,
	input wire logic [W-1:0][1:0]        ID_OUT,
	input wire logic [W-1:0]             ID_WEAK_OUT,
	input wire logic [1:0]               TF_FORCE_ONE_N,
	input wire logic [1:0]               TF_FORCE_ZERO_N,
	input wire logic [W-1:0][1:0]        TF_Q,
	input wire logic [W-1:0][1:0]        TF_Q_N,
	input wire logic [1:0]               LT_EN,
	input wire logic [W-1:0][1:0]        LT_Q,
	input wire logic [1:0]               FL_FORCE_ZERO_N,
	input wire logic [W-1:0][1:0]        FL_Q
);
	// ------------------------------------------------
	// outputs are meaningful one edge after reset ends
	// ------------------------------------------------
	logic live;
	always_ff @(posedge SYS_CLK) begin
		live <= !SYS_RST;
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	chk_and_zero: assert property (live && (AND_IN[0][0] == 2'h0 || AND_IN[N-1][0] == 2'h0)
		|=> AND_OUT[0] == {1'b0, GATE_INV[fsl_pkg::INV_Q]}) else $error("and output wrong");
	chk_or_one: assert property (live && OR_IN[0][0] == 2'h1
		|=> OR_OUT[0] == {1'b0, !GATE_INV[fsl_pkg::INV_QN]}) else $error("or output wrong");
	chk_buf_unknown: assert property (live && BUF_IN[0][1] |=> BUF_OUT[0] == 2'h3)
		else $error("buffer did not give unknown");
	chk_tsd_off: assert property (live && TSD_EN_N == 2'h1 |=> TSD_OUT[0] == 2'h2)
		else $error("driver not released");
	chk_id_exact: assert property (live
		|=> ID_OUT == $past(ID_IN) && ID_WEAK_OUT == $past(ID_WEAK_IN)) else $error("identity");
	chk_tf_both_forced: assert property (live && TF_FORCE_ONE_N == 2'h0
		&& TF_FORCE_ZERO_N == 2'h0 |=> TF_Q[0] == 2'h1 && TF_Q_N[0] == 2'h1)
		else $error("toggle flop forces");
	chk_lt_hold: assert property (live && LT_EN == 2'h0 |=> LT_Q == $past(LT_Q))
		else $error("latch did not hold");
	chk_fl_zero_wins: assert property (live && FL_FORCE_ZERO_N == 2'h0 |=> FL_Q[0] == 2'h0)
		else $error("forced latch not low");
endmodule

bind fsl_prims fsl_prims_properties #(.W(W), .N(N), .GATE_INV(GATE_INV)) u_props (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .AND_IN(AND_IN), .AND_OUT(AND_OUT),
	.OR_IN(OR_IN), .OR_OUT(OR_OUT), .BUF_IN(BUF_IN), .BUF_OUT(BUF_OUT),
	.TSD_EN_N(TSD_EN_N), .TSD_OUT(TSD_OUT), .ID_IN(ID_IN), .ID_WEAK_IN(ID_WEAK_IN),
	.ID_OUT(ID_OUT), .ID_WEAK_OUT(ID_WEAK_OUT), .TF_FORCE_ONE_N(TF_FORCE_ONE_N),
	.TF_FORCE_ZERO_N(TF_FORCE_ZERO_N), .TF_Q(TF_Q), .TF_Q_N(TF_Q_N), .LT_EN(LT_EN),
	.LT_Q(LT_Q), .FL_FORCE_ZERO_N(FL_FORCE_ZERO_N), .FL_Q(FL_Q)
);

// [dv/fsl_prims_tb_top.sv]
// self-checking testbench for the four-state primitive library
`timescale 1ns/1ps
module fsl_prims_tb_top;
	logic            clk, rst, id_weak_in, id_weak_out;
	logic [2:0][1:0] and_in, or_in;
	logic [1:0]      and_out, or_out, xor_a, xor_b, xor_out, buf_in, buf_out, tsd_in, tsd_en_n;
	logic [1:0]      tsd_out, id_in, id_out, tf_j, tf_k, tf_clk, tf_one_n, tf_zero_n, tf_q, tf_q_n;
	logic [1:0]      lt_d, lt_en, lt_q, fl_d, fl_en, fl_one_n, fl_zero_n, fl_q;
	logic [1:0]      dl_d, dl_en, dl_one_n, dl_zero_n, dl_q, dl_q_n;
	int              err_count, n_compared;

	// or output inverted to make a nor
	fsl_prims #(.N(3), .GATE_INV(7'h20)) dut (
		.SYS_CLK(clk), .SYS_RST(rst), .AND_IN(and_in), .AND_OUT(and_out), .OR_IN(or_in),
		.OR_OUT(or_out), .XOR_A(xor_a), .XOR_B(xor_b), .XOR_OUT(xor_out), .BUF_IN(buf_in),
		.BUF_OUT(buf_out), .TSD_IN(tsd_in), .TSD_EN_N(tsd_en_n), .TSD_OUT(tsd_out),
		.ID_IN(id_in), .ID_WEAK_IN(id_weak_in), .ID_OUT(id_out), .ID_WEAK_OUT(id_weak_out),
		.TF_J(tf_j), .TF_K(tf_k), .TF_CLK(tf_clk), .TF_FORCE_ONE_N(tf_one_n),
		.TF_FORCE_ZERO_N(tf_zero_n), .TF_Q(tf_q), .TF_Q_N(tf_q_n), .LT_D(lt_d), .LT_EN(lt_en),
		.LT_Q(lt_q), .FL_D(fl_d), .FL_EN(fl_en), .FL_FORCE_ONE_N(fl_one_n),
		.FL_FORCE_ZERO_N(fl_zero_n), .FL_Q(fl_q), .DL_D(dl_d), .DL_EN(dl_en),
		.DL_FORCE_ONE_N(dl_one_n), .DL_FORCE_ZERO_N(dl_zero_n), .DL_Q(dl_q), .DL_Q_N(dl_q_n)
	);

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic tick;
		@(negedge clk);
	endtask

	task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// dominant value wins, all identity gives identity, otherwise unknown
	function automatic logic [1:0] e_gate(input logic [5:0] v, input logic [1:0] dom);
		e_gate = {1'b0, ~dom[0]};
		for (int i = 0; i < 3; i++) begin
			if (v[2*i +: 2] == dom)
				return dom;
			if (v[2*i+1])
				e_gate = 2'h3;
		end
	endfunction

	// ------------------------------------------------
	// scenarios; table rows hold one hex digit per pin
	// ------------------------------------------------
	task automatic t_comb;
		logic [1:0] a, b, c, o;
		for (int i = 0; i < 64; i++) begin
			{c, b, a} = i[5:0];
			{and_in, or_in} = {c, b, a, c, b, a};
			{xor_a, xor_b, buf_in, tsd_in, tsd_en_n} = {a, b, a, a, c};
			{id_in, id_weak_in} = {b, a[0]};
			tick;
			o = e_gate(i[5:0], 2'h1);
			check("and", and_out, e_gate(i[5:0], 2'h0));
			check("nor", or_out, o[1] ? o : o ^ 2'h1);
			check("xor", xor_out, (a[1] || b[1]) ? 2'h3 : {1'b0, a[0] ^ b[0]});
			check("buf", buf_out, a[1] ? 2'h3 : a);
			check("tsd", tsd_out, c == 2'h0 ? (a[1] ? 2'h3 : a) : (c == 2'h1 ? 2'h2 : 2'h3));
			check("id", id_out, b);
			check("idweak", {1'b0, id_weak_out}, {1'b0, a[0]});
		end
		$display("test comb done");
	endtask

	task automatic t_tflop;
		logic [27:0] rows [20] = '{28'h0010010, 28'h0100001, 28'h0000011, 28'h0310033,
			28'h0120033, 28'h0100001, 28'h0111001, 28'h1111010, 28'h1110110, 28'h0110110,
			28'h1110101, 28'h0111101, 28'h1111110, 28'h0110010, 28'h1110010, 28'h0113010,
			28'h1113033, 28'h0100001, 28'h0110001, 28'h3110033};
		foreach (rows[i]) begin
			{tf_clk, tf_one_n} = {rows[i][25:24], rows[i][21:20]};
			{tf_zero_n, tf_j, tf_k} = {rows[i][17:16], rows[i][13:12], rows[i][9:8]};
			tick;
			check("tf_q", tf_q, rows[i][5:4]);
			check("tf_q_n", tf_q_n, rows[i][1:0]);
		end
		$display("test tflop done");
	endtask

	task automatic t_latch;
		logic [11:0] rows [9] = '{12'h100, 12'h111, 12'h001, 12'h123, 12'h111, 12'h311,
			12'h203, 12'h100, 12'h030};
		foreach (rows[i]) begin
			{lt_en, lt_d} = {rows[i][9:8], rows[i][5:4]};
			tick;
			check("lt_q", lt_q, rows[i][1:0]);
		end
		$display("test latch done");
	endtask

	task automatic t_forced;
		logic [19:0] rows [8] = '{20'h00011, 20'h01100, 20'h11000, 20'h00300, 20'h00133,
			20'h11111, 20'h00111, 20'h31111};
		foreach (rows[i]) begin
			{fl_en, fl_d} = {rows[i][17:16], rows[i][13:12]};
			{fl_one_n, fl_zero_n} = {rows[i][9:8], rows[i][5:4]};
			tick;
			check("fl_q", fl_q, rows[i][1:0]);
		end
		$display("test forced done");
	endtask

	task automatic t_dual;
		logic [23:0] rows [9] = '{24'h000011, 24'h000110, 24'h001001, 24'h002133, 24'h111110,
			24'h001110, 24'h101101, 24'h301101, 24'h311133};
		foreach (rows[i]) begin
			{dl_en, dl_d} = {rows[i][21:20], rows[i][17:16]};
			{dl_one_n, dl_zero_n} = {rows[i][13:12], rows[i][9:8]};
			tick;
			check("dl_q", dl_q, rows[i][5:4]);
			check("dl_q_n", dl_q_n, rows[i][1:0]);
		end
		$display("test dual done");
	endtask

	// ------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (2000) @(posedge clk);
		err_count++;
		finish_test;
	end

	initial begin
		rst = 1'b1;
		{and_in, or_in, xor_a, xor_b, buf_in, tsd_in, tsd_en_n, id_in, id_weak_in} = '0;
		{tf_j, tf_k, tf_clk, tf_one_n, tf_zero_n, lt_d, lt_en} = '0;
		{fl_d, fl_en, fl_one_n, fl_zero_n, dl_d, dl_en, dl_one_n, dl_zero_n} = '0;
		repeat (16) @(posedge clk);
		tick;
		rst = 1'b0;
		repeat (3) tick;
		t_comb;
		t_tflop;
		t_latch;
		t_forced;
		t_dual;
		finish_test;
	end
endmodule
